/* File: ctm_map.svh */
// Register offsets, field positions, reset values and constants of the counter/timer
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
`define CTM_ADDR_W 12
`define CTM_OFF_FLAGS 12'h000
`define CTM_OFF_CTRL 12'h004
`define CTM_OFF_TC 12'h008
`define CTM_OFF_LIMIT 12'h00c
`define CTM_OFF_DIV 12'h010
`define CTM_OFF_ACT 12'h014
`define CTM_OFF_CMP0 12'h018
`define CTM_OFF_CMP1 12'h01c
`define CTM_OFF_CMP2 12'h020
`define CTM_OFF_CMP3 12'h024
`define CTM_OFF_EDGE 12'h028
`define CTM_OFF_CAP0 12'h02c
`define CTM_OFF_CAP1 12'h030
`define CTM_OFF_EXT 12'h03c
`define CTM_OFF_SRC 12'h070
`define CTM_OFF_PWM 12'h074
`define CTM_CTRL_CEN_BIT 0
`define CTM_CTRL_COUNTER_SYNC_RESET_BIT_BIT 1
`define CTM_ACT_FIELD_W 3
`define CTM_EDGE_FIELD_W 3
`define CTM_EXT_CTRL_LSB 4
`define CTM_EXT_CTRL_W 2
`define CTM_SRC_MODE_LSB 0
`define CTM_SRC_SEL_LSB 2
`define CTM_CAP0_FLAG_BIT 4
`define CTM_CAP1_BIT_INST0 6
`define CTM_CAP1_BIT_INST1 5
`define CTM_RST_CORE '0
`define CTM_RST_BUS '0
`define CTM_RESP_OKAY 2'h0
`endif

/* File: ctm_pin_model.sv */
// Far-side model driving the two capture input pins
`timescale 1ns/1ps
module ctm_pin_model (
   input wire logic core_clk_in,
   output logic [1:0] cap_out
);
   initial cap_out = 2'h0;
   // Each level is held eight clocks so the input synchroniser sees both edges
   task automatic pulse(input int ch, input int n);
      repeat (n) begin
         @(posedge core_clk_in);
         cap_out[ch] <= 1'b1;
         repeat (8) @(posedge core_clk_in);
         cap_out[ch] <= 1'b0;
         repeat (8) @(posedge core_clk_in);
      end
   endtask
endmodule

/* File: ctm_pkg.sv */
// Types shared by the counter/timer design
package ctm_pkg;
   typedef logic [15:0] ctm_cnt_t;
   typedef enum logic [1:0] {
      CTM_MODE_TIMER = 2'b00,
      CTM_MODE_RISE = 2'b01,
      CTM_MODE_FALL = 2'b10,
      CTM_MODE_BOTH = 2'b11
   } ctm_mode_t;
   typedef struct packed {
      logic stop;
      logic rst;
      logic irq;
   } ctm_act_t;
   typedef struct packed {
      logic irq;
      logic fall;
      logic rise;
   } ctm_edge_t;
   typedef struct packed {
      logic counter_enable_bit;
      logic counter_sync_reset_bit;
      ctm_cnt_t tc;
      ctm_cnt_t limit;
      ctm_cnt_t div;
      logic [11:0] act;
      ctm_cnt_t [3:0] cmp;
      logic [5:0] edge_cfg;
      ctm_cnt_t [1:0] cap;
      logic [11:0] ext;
      logic [3:0] src;
      logic [3:0] pwm;
      logic [5:0] flag;
      logic [1:0] lvl;
      logic [1:0] pin;
   } ctm_core_t;
   typedef struct packed {
      logic awready;
      logic aw_have;
      logic [11:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
   } ctm_bus_t;
endpackage

/* File: ctm_tb.sv */
// Self-checking testbench for the counter/timer
`timescale 1ns/1ps
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] awa = 12'h0;
   logic [11:0] ara = 12'h0;
   logic [31:0] wd = 32'h0;
   logic awv = 1'b0;
   logic wv = 1'b0;
   logic bre = 1'b0;
   logic arv = 1'b0;
   logic rre = 1'b0;
   logic awr, wrd, bv, arr, rv;
   logic [1:0] pins, cap;
   logic [31:0] rdat, d;
   int miscompares = 0;
   int total_checks = 0;
   int cyc = 0;
   int t0;
   logic [11:0] ro [12] = '{12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h028,
      12'h03c, 12'h070, 12'h074};
   logic [15:0] mk [12] = '{16'hffff, 16'hffff, 16'hffff, 16'h0fff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
      16'h003f, 16'h0fff, 16'h000f, 16'h000f};
   logic [11:0] xo [7] = '{12'h000, 12'h004, 12'h02c, 12'h030, 12'h034, 12'h040, 12'h06c};
   always #50 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   ctm_timer ctm_timer_inst (.core_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
      .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrd), .s_axi_bresp_out(), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre),
      .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
      .s_axi_rresp_out(), .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .capture_input_0_in(cap[0]),
      .capture_input_1_in(cap[1]), .compare_output_pins_b_out(pins));
   ctm_pin_model ctm_pin_model_inst (.core_clk_in(clk), .cap_out(cap));
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Handshake edge is one clock after the write lands; t0 keeps that edge for timing
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      int i = 0;
      @(posedge clk);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      do begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrd) wv <= 1'b0;
         if (bre && bv) begin
            bre <= 1'b0;
            t0 = cyc;
         end
         i++;
      end while (i < 40 && (awv || wv || bre));
      if (bre) begin
         $display("ERROR %0t: write timed out", $time);
         miscompares++;
         summarize();
      end
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] exp);
      int i = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rre && rv) begin
            rre <= 1'b0;
            d = rdat;
         end
         i++;
      end while (i < 40 && (arv || rre));
      if (rre) begin
         $display("ERROR %0t: read timed out", $time);
         miscompares++;
         summarize();
      end
      chk(d, exp);
   endtask
   task automatic t_regs;
      foreach (ro[i]) rc(ro[i], 32'h0);
      foreach (xo[i]) rc(xo[i], 32'h0);
      foreach (ro[i]) begin
         wr(ro[i], 32'hffffffff);
         rc(ro[i], {16'h0, mk[i]});
         wr(ro[i], 32'h0);
      end
      for (int i = 2; i < 5; i++) begin
         wr(xo[i], 32'hffffffff);
         rc(xo[i], 32'h0);
      end
      $display("register test done");
   endtask
   task automatic t_count(input logic [15:0] lim, input logic [15:0] st);
      int n;
      wr(12'h00c, {16'h0, lim});
      wr(12'h008, {16'h0, st});
      wr(12'h004, 32'h1);
      n = t0;
      repeat (37) @(posedge clk);
      wr(12'h004, 32'h0);
      n = t0 - n;
      rc(12'h008, {16'h0, st + 16'(n / (lim + 1))});
      rc(12'h010, 32'(n % (lim + 1)));
      rc(12'h000, 32'h0);
      wr(12'h010, 32'h0);
      $display("count test done");
   endtask
   task automatic t_match;
      wr(12'h008, 32'h5);
      wr(12'h004, 32'h3);
      repeat (10) @(posedge clk);
      rc(12'h008, 32'h0);
      rc(12'h010, 32'h0);
      wr(12'h01c, 32'h3);
      wr(12'h014, 32'h18);
      wr(12'h004, 32'h1);
      repeat (30) @(posedge clk);
      wr(12'h004, 32'h0);
      rc(12'h000, 32'h2);
      wr(12'h000, 32'h0);
      rc(12'h000, 32'h2);
      wr(12'h000, 32'h2);
      rc(12'h000, 32'h0);
      wr(12'h018, 32'h2);
      wr(12'h008, 32'h0);
      wr(12'h014, 32'h5);
      wr(12'h004, 32'h1);
      repeat (20) @(posedge clk);
      rc(12'h004, 32'h0);
      rc(12'h008, 32'h2);
      rc(12'h000, 32'h1);
      wr(12'h000, 32'h1);
      wr(12'h014, 32'h0);
      $display("compare test done");
   endtask
   task automatic t_cap;
      wr(12'h008, 32'h1234);
      wr(12'h028, 32'h5);
      ctm_pin_model_inst.pulse(0, 1);
      rc(12'h02c, 32'h1234);
      rc(12'h000, 32'h10);
      wr(12'h000, 32'h10);
      wr(12'h008, 32'habc);
      wr(12'h028, 32'h30);
      ctm_pin_model_inst.pulse(1, 1);
      rc(12'h030, 32'habc);
      rc(12'h02c, 32'h1234);
      rc(12'h000, 32'h20);
      wr(12'h000, 32'h20);
      wr(12'h028, 32'h0);
      wr(12'h008, 32'h0);
      wr(12'h070, 32'h1);
      wr(12'h004, 32'h1);
      ctm_pin_model_inst.pulse(0, 3);
      wr(12'h004, 32'h0);
      rc(12'h008, 32'h3);
      wr(12'h070, 32'h0);
      $display("capture test done");
   endtask
   task automatic t_pins;
      wr(12'h018, 32'h1);
      wr(12'h008, 32'h0);
      wr(12'h03c, 32'h20);
      wr(12'h004, 32'h1);
      repeat (10) @(posedge clk);
      wr(12'h004, 32'h0);
      rc(12'h03c, 32'h21);
      wr(12'h01c, 32'h8);
      wr(12'h008, 32'h10);
      wr(12'h074, 32'h2);
      repeat (2) @(posedge clk);
      chk({30'h0, pins}, 32'h3);
      wr(12'h008, 32'h4);
      repeat (2) @(posedge clk);
      chk({30'h0, pins}, 32'h1);
      $display("output pin test done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_count(16'h3, 16'h0);
      t_count(16'h0, 16'hffe0);
      t_match();
      t_cap();
      t_pins();
      summarize();
   end
endmodule

/* File: ctm_timer.sv */
// 16-bit counter/timer with compare, capture, PWM outputs and an AXI4-Lite register slave
`timescale 1ns/1ps
`include "ctm_map.svh"
module ctm_timer
   import ctm_pkg::*;
#(
   parameter int unsigned CAP1_FLAG_BIT = `CTM_CAP1_BIT_INST1
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [11:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [11:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic capture_input_0_in,
   input wire logic capture_input_1_in,
   output logic [1:0] compare_output_pins_b_out
);

   ctm_core_t core_r;
   ctm_core_t core_nxt;
   ctm_bus_t bus_r;
   ctm_bus_t bus_nxt;
   logic [1:0] sync1_r;
   logic [1:0] sync2_r;
   logic [1:0] sync3_r;
   logic wr_fire;
   logic [31:0] wr_mask;

   function automatic logic [31:0] ctm_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [31:0] mask);
      ctm_merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   function automatic ctm_act_t ctm_get_act(input logic [11:0] act, input int idx);
      ctm_get_act = ctm_act_t'(act[idx * `CTM_ACT_FIELD_W +: `CTM_ACT_FIELD_W]);
   endfunction

   function automatic ctm_edge_t ctm_get_edge(input logic [5:0] cfg, input int idx);
      ctm_get_edge = ctm_edge_t'(cfg[idx * `CTM_EDGE_FIELD_W +: `CTM_EDGE_FIELD_W]);
   endfunction

   // Flag vector as software sees it; capture flag 1 moves with the instance
   function automatic logic [31:0] ctm_flags_view(input logic [5:0] flag);
      logic [31:0] v;
      v = 32'h0;
      v[3:0] = flag[3:0];
      v[`CTM_CAP0_FLAG_BIT] = flag[4];
      v[CAP1_FLAG_BIT] = flag[5];
      return v;
   endfunction

   function automatic logic [31:0] ctm_read(input logic [11:0] addr, input ctm_core_t c);
      logic [31:0] v;
      v = 32'h0;
      unique case (addr)
         `CTM_OFF_FLAGS: v = ctm_flags_view(c.flag);
         `CTM_OFF_CTRL: v[1:0] = {c.counter_sync_reset_bit, c.counter_enable_bit};
         `CTM_OFF_TC: v[15:0] = c.tc;
         `CTM_OFF_LIMIT: v[15:0] = c.limit;
         `CTM_OFF_DIV: v[15:0] = c.div;
         `CTM_OFF_ACT: v[11:0] = c.act;
         `CTM_OFF_CMP0: v[15:0] = c.cmp[0];
         `CTM_OFF_CMP1: v[15:0] = c.cmp[1];
         `CTM_OFF_CMP2: v[15:0] = c.cmp[2];
         `CTM_OFF_CMP3: v[15:0] = c.cmp[3];
         `CTM_OFF_EDGE: v[5:0] = c.edge_cfg;
         `CTM_OFF_CAP0: v[15:0] = c.cap[0];
         `CTM_OFF_CAP1: v[15:0] = c.cap[1];
         `CTM_OFF_EXT: v[11:0] = c.ext;
         `CTM_OFF_SRC: v[3:0] = c.src;
         `CTM_OFF_PWM: v[3:0] = c.pwm;
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   // Bus slave: address and data are taken independently, the write lands once both are held
   always_comb begin
      logic aw_take;
      logic w_take;
      logic ar_take;
      aw_take = s_axi_awvalid_in & bus_r.awready;
      w_take = s_axi_wvalid_in & ~bus_r.w_have;
      ar_take = s_axi_arvalid_in & bus_r.arready;
      bus_nxt = bus_r;
      wr_fire = bus_r.aw_have & bus_r.w_have & ~bus_r.bvalid;
      wr_mask = {{8{bus_r.w_strb[3]}}, {8{bus_r.w_strb[2]}}, {8{bus_r.w_strb[1]}}, {8{bus_r.w_strb[0]}}};
      if (aw_take) begin
         bus_nxt.aw_have = 1'b1;
         bus_nxt.aw_addr = s_axi_awaddr_in;
      end
      if (w_take) begin
         bus_nxt.w_have = 1'b1;
         bus_nxt.w_data = s_axi_wdata_in;
         bus_nxt.w_strb = s_axi_wstrb_in;
      end
      if (wr_fire) begin
         bus_nxt.aw_have = 1'b0;
         bus_nxt.w_have = 1'b0;
         bus_nxt.bvalid = 1'b1;
      end else if (bus_r.bvalid & s_axi_bready_in) begin
         bus_nxt.bvalid = 1'b0;
      end
      bus_nxt.awready = ~bus_nxt.aw_have;
      if (ar_take) begin
         bus_nxt.rvalid = 1'b1;
         bus_nxt.rdata = ctm_read(s_axi_araddr_in, core_r);
      end else if (bus_r.rvalid & s_axi_rready_in) begin
         bus_nxt.rvalid = 1'b0;
      end
      bus_nxt.arready = ~bus_nxt.rvalid;
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         bus_r <= `CTM_RST_BUS;
      end else begin
         bus_r <= bus_nxt;
      end
   end

   // Three-stage pin synchroniser; only stages two and three feed the edge logic
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync1_r <= 2'h0;
         sync2_r <= 2'h0;
         sync3_r <= 2'h0;
      end else begin
         sync1_r <= {capture_input_1_in, capture_input_0_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   always_comb begin
      logic [1:0] rise;
      logic [1:0] fall;
      logic tick;
      logic src_rise;
      logic src_fall;
      logic run;
      logic inc;
      logic any_rst;
      logic any_stop;
      logic [3:0] hit;
      logic [5:0] set_flag;
      logic [31:0] wv;
      ctm_act_t a;
      ctm_edge_t e;
      rise = 2'h0;
      fall = 2'h0;
      tick = 1'b0;
      src_rise = 1'b0;
      src_fall = 1'b0;
      run = 1'b0;
      inc = 1'b0;
      any_rst = 1'b0;
      any_stop = 1'b0;
      hit = 4'h0;
      set_flag = 6'h0;
      wv = 32'h0;
      a = '0;
      e = '0;
      core_nxt = core_r;

      // A change counts once stages two and three agree
      for (int i = 0; i < 2; i++) begin
         if ((sync2_r[i] == sync3_r[i]) && (sync3_r[i] != core_r.lvl[i])) begin
            rise[i] = sync3_r[i];
            fall[i] = ~sync3_r[i];
            core_nxt.lvl[i] = sync3_r[i];
         end
      end

      // Counter mode counts chosen edges of the selected pin; select codes above one count nothing
      unique case (core_r.src[3:2])
         2'b00: begin
            src_rise = rise[0];
            src_fall = fall[0];
         end
         2'b01: begin
            src_rise = rise[1];
            src_fall = fall[1];
         end
         default: begin
            src_rise = 1'b0;
            src_fall = 1'b0;
         end
      endcase
      unique case (ctm_mode_t'(core_r.src[1:0]))
         CTM_MODE_TIMER: tick = 1'b1;
         CTM_MODE_RISE: tick = src_rise;
         CTM_MODE_FALL: tick = src_fall;
         CTM_MODE_BOTH: tick = src_rise | src_fall;
      endcase

      run = core_r.counter_enable_bit & ~core_r.counter_sync_reset_bit & tick;
      inc = run & (core_r.div == core_r.limit);
      if (run) begin
         core_nxt.div = inc ? 16'h0 : core_r.div + 16'h1;
      end
      if (inc) begin
         core_nxt.tc = core_r.tc + 16'h1;
      end

      // Compare channels act at the moment the count would step
      for (int i = 0; i < 4; i++) begin
         a = ctm_get_act(core_r.act, i);
         hit[i] = inc & (core_r.tc == core_r.cmp[i]);
         if (hit[i]) begin
            set_flag[i] = a.irq;
            any_rst = any_rst | a.rst;
            any_stop = any_stop | a.stop;
            unique case (core_r.ext[`CTM_EXT_CTRL_LSB + i * `CTM_EXT_CTRL_W +: `CTM_EXT_CTRL_W])
               2'b01: core_nxt.ext[i] = 1'b0;
               2'b10: core_nxt.ext[i] = 1'b1;
               2'b11: core_nxt.ext[i] = ~core_r.ext[i];
               default: core_nxt.ext[i] = core_r.ext[i];
            endcase
         end
      end
      if (any_stop) begin
         core_nxt.tc = core_r.tc;
      end
      if (any_rst) begin
         core_nxt.tc = 16'h0;
      end

      // Captures sample the count that stands in the edge cycle
      for (int i = 0; i < 2; i++) begin
         e = ctm_get_edge(core_r.edge_cfg, i);
         if ((e.rise & rise[i]) | (e.fall & fall[i])) begin
            core_nxt.cap[i] = core_r.tc;
            set_flag[4 + i] = e.irq;
         end
      end

      // Software writes; capture registers take none
      if (wr_fire) begin
         unique case (bus_r.aw_addr)
            `CTM_OFF_FLAGS: begin
               wv = bus_r.w_data & wr_mask;
               core_nxt.flag[3:0] = core_r.flag[3:0] & ~wv[3:0];
               core_nxt.flag[4] = core_r.flag[4] & ~wv[`CTM_CAP0_FLAG_BIT];
               core_nxt.flag[5] = core_r.flag[5] & ~wv[CAP1_FLAG_BIT];
            end
            `CTM_OFF_CTRL: begin
               wv = ctm_merge({30'h0, core_r.counter_sync_reset_bit, core_r.counter_enable_bit}, bus_r.w_data, wr_mask);
               core_nxt.counter_enable_bit = wv[`CTM_CTRL_CEN_BIT];
               core_nxt.counter_sync_reset_bit = wv[`CTM_CTRL_COUNTER_SYNC_RESET_BIT_BIT];
            end
            `CTM_OFF_TC: core_nxt.tc = 16'(ctm_merge({16'h0, core_r.tc}, bus_r.w_data, wr_mask));
            `CTM_OFF_LIMIT: core_nxt.limit = 16'(ctm_merge({16'h0, core_r.limit}, bus_r.w_data, wr_mask));
            `CTM_OFF_DIV: core_nxt.div = 16'(ctm_merge({16'h0, core_r.div}, bus_r.w_data, wr_mask));
            `CTM_OFF_ACT: core_nxt.act = 12'(ctm_merge({20'h0, core_r.act}, bus_r.w_data, wr_mask));
            `CTM_OFF_CMP0: core_nxt.cmp[0] = 16'(ctm_merge({16'h0, core_r.cmp[0]}, bus_r.w_data, wr_mask));
            `CTM_OFF_CMP1: core_nxt.cmp[1] = 16'(ctm_merge({16'h0, core_r.cmp[1]}, bus_r.w_data, wr_mask));
            `CTM_OFF_CMP2: core_nxt.cmp[2] = 16'(ctm_merge({16'h0, core_r.cmp[2]}, bus_r.w_data, wr_mask));
            `CTM_OFF_CMP3: core_nxt.cmp[3] = 16'(ctm_merge({16'h0, core_r.cmp[3]}, bus_r.w_data, wr_mask));
            `CTM_OFF_EDGE: core_nxt.edge_cfg = 6'(ctm_merge({26'h0, core_r.edge_cfg}, bus_r.w_data, wr_mask));
            `CTM_OFF_EXT: core_nxt.ext = 12'(ctm_merge({20'h0, core_r.ext}, bus_r.w_data, wr_mask));
            `CTM_OFF_SRC: core_nxt.src = 4'(ctm_merge({28'h0, core_r.src}, bus_r.w_data, wr_mask));
            `CTM_OFF_PWM: core_nxt.pwm = 4'(ctm_merge({28'h0, core_r.pwm}, bus_r.w_data, wr_mask));
            default: wv = 32'h0;
         endcase
      end

      // Hardware set beats a simultaneous software clear
      core_nxt.flag = core_nxt.flag | set_flag;
      if (any_stop) begin
         core_nxt.counter_enable_bit = 1'b0;
      end
      if (core_r.counter_sync_reset_bit) begin
         core_nxt.tc = 16'h0;
         core_nxt.div = 16'h0;
      end

      // PWM pins go high once the count reaches the compare value
      for (int i = 0; i < 2; i++) begin
         core_nxt.pin[i] = core_r.pwm[i] ? (core_r.tc >= core_r.cmp[i]) : core_r.ext[i];
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         core_r <= `CTM_RST_CORE;
      end else begin
         core_r <= core_nxt;
      end
   end

   assign s_axi_awready_out = bus_r.awready;
   assign s_axi_wready_out = ~bus_r.w_have;
   assign s_axi_bresp_out = `CTM_RESP_OKAY;
   assign s_axi_bvalid_out = bus_r.bvalid;
   assign s_axi_arready_out = bus_r.arready;
   assign s_axi_rdata_out = bus_r.rdata;
   assign s_axi_rresp_out = `CTM_RESP_OKAY;
   assign s_axi_rvalid_out = bus_r.rvalid;
   assign compare_output_pins_b_out = core_r.pin;

endmodule

/* File: ctm_timer_properties.sv */
// Bus handshake and reset assertions for the counter/timer, bound to its top module
`timescale 1ns/1ps
module ctm_timer_properties (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic s_axi_awvalid_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic s_axi_wready_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   input wire logic [1:0] compare_output_pins_b_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   chk_write_answer: assert property (
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write not answered two cycles after address and data");
   chk_read_answer: assert property (
      s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
      else $error("read not answered one cycle after address");
   chk_bvalid_done: assert property (
      s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
      else $error("write response stayed after acceptance");
   chk_rvalid_done: assert property (
      s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out)
      else $error("read data stayed or read address blocked after acceptance");
   chk_read_block: assert property (
      s_axi_rvalid_out |-> !s_axi_arready_out)
      else $error("read address accepted while read data pending");
   chk_bresp_okay: assert property (
      s_axi_bvalid_out |-> s_axi_bresp_out == 2'h0)
      else $error("write response not okay");
   chk_rresp_okay: assert property (
      s_axi_rvalid_out |-> s_axi_rresp_out == 2'h0)
      else $error("read response not okay");
   chk_reset_quiet: assert property (
      $fell(rst_in) |-> !s_axi_bvalid_out && !s_axi_rvalid_out && !s_axi_arready_out
      && compare_output_pins_b_out == 2'h0)
      else $error("outputs not cleared by reset");
endmodule
bind ctm_timer ctm_timer_properties ctm_timer_properties_inst (.core_clk_in(core_clk_in), .rst_in(rst_in),
   .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out), .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_rready_in(s_axi_rready_in), .compare_output_pins_b_out(compare_output_pins_b_out));
